// file: rtl/sfr_map.svh
// Purpose: Offsets, field positions, reset values and constants of the
//          special function register bank.
// Assumes: Included by bare name from the bank's design file.
// Notes:   Definitions only.
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// Control space offsets (page 0)
`define OFS_P5_DIR 8'h05
`define OFS_P6_DIR 8'h06
`define OFS_P7_DIR 8'h07
`define OFS_P8_DIR 8'h08
`define OFS_MEM_PTR 8'h09
`define OFS_MEM_WIN 8'h0a
`define OFS_CNT1_PRESET 8'h0b
// Data space offsets
`define OFS_SYS_CLK 8'h0d
`define OFS_REMOTE 8'h0e
`define OFS_IRQ_FLAGS 8'h0f

// Reset values
`define RST_DIR 8'hff
`define RST_ZERO 8'h00

// System clock control fields
`define SBP_SRC 0
`define SBP_BF_LO 1
`define SBP_IDLE 3
`define SBP_CLK_LO 4
`define SBP_CLK_HI 6

// Remote output control fields
`define RMT_EN 7
`define RMT_CARRIER 6
`define RMT_LOW_ONLY 5
`define RMT_PIN 3
`define RMT_TICK 2
`define RMT_EXTB 1
`define RMT_EXTA 0

// Interrupt flag positions
`define ISR_PORT_CHG 7
`define ISR_LPWT 6
`define ISR_HPWT 5
`define ISR_CNT2 4
`define ISR_CNT1 3
`define ISR_EXT_B 2
`define ISR_EXT_A 1
`define ISR_TICK 0

// PLL multipliers
`define MUL_X130 8'h82
`define MUL_X65 8'h41
`define MUL_X244 8'hf4

// Booster divide counts, minus one
`define BOOST_DIV1 4'h0
`define BOOST_DIV4 4'h3
`define BOOST_DIV8 4'h7
`define BOOST_DIV16 4'hf

`endif

// file: rtl/sfr_pkg.sv
// Purpose: Types shared by the special function register bank.
// Assumes: Nothing.
// Notes:   Constants live in sfr_map.svh.
package sfr_pkg;
    typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP} power_state_t;
    typedef enum logic {SPACE_DATA, SPACE_CTRL} sfr_space_t;
endpackage

// file: rtl/mcu_special_function_regs.sv
// Purpose: Special function registers of the 8-bit core: clocking, power
//          mode, remote waveform, port direction, flags, aux memory, counter 1.
// Assumes: Core access port on ref_clk_i; timers other than counter 1 live
//          outside and report underflow as one-cycle pulses.
// Notes:   Read data appears one cycle after the read strobe.
`include "sfr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mcu_special_function_regs #(
    parameter int MEM_DEPTH = 128
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire sfr_pkg::sfr_space_t sfr_space_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic control_page_select_i,
    input wire logic low_power_instruction_i,
    input wire logic wake_i,
    output sfr_pkg::power_state_t power_state_o,
    input wire logic slow_tick_i,
    output logic [7:0] pll_mult_num_o,
    output logic [1:0] pll_mult_shift_o,
    output logic cpu_source_select_o,
    output logic main_osc_enable_o,
    output logic booster_tick_o,
    input wire logic hpwt_uf_i,
    input wire logic lpwt_uf_i,
    input wire logic cnt2_uf_i,
    input wire logic tick_ovf_i,
    input wire logic cnt1_tick_i,
    input wire logic counter_one_enable_i,
    input wire logic [2:0] cnt1_prescale_i,
    output logic [7:0] irq_flags_o,
    output logic tick_pin_o,
    input wire logic [7:4] p5_data_i,
    input wire logic [7:4] p5_pin_i,
    output logic [7:4] p5_o,
    output logic [7:4] p5_oe_o,
    input wire logic [7:0] p6_data_i,
    input wire logic [7:0] p6_pin_i,
    output logic [7:0] p6_o,
    output logic [7:0] p6_oe_o,
    input wire logic [7:0] p7_data_i,
    output logic [7:0] p7_o,
    output logic [7:0] p7_oe_o,
    input wire logic [7:0] p8_data_i,
    input wire logic [7:0] p8_pin_i,
    output logic [7:0] p8_o,
    output logic [7:0] p8_oe_o,
    input wire logic [31:16] lcd_seg_i
);
    import sfr_pkg::*;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [7:0] mult_num(input logic [2:0] code);
        logic [7:0] r;
        r = `MUL_X65;
        if (code[2]) begin
            r = `MUL_X244;
        end else if (code[1:0] == 2'b00) begin
            r = `MUL_X130;
        end
        return r;
    endfunction

    function automatic logic [1:0] mult_shift(input logic [2:0] code);
        logic [1:0] r;
        r = 2'h0;
        if (!code[2] && code[1]) begin
            r = code[0] ? 2'h2 : 2'h1;
        end
        return r;
    endfunction

    function automatic logic [3:0] boost_top(input logic [1:0] code);
        logic [3:0] r;
        unique case (code)
            2'b00: r = `BOOST_DIV1;
            2'b01: r = `BOOST_DIV4;
            2'b10: r = `BOOST_DIV8;
            2'b11: r = `BOOST_DIV16;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Register access decode
    // ************************************************************
    logic [7:0] p5_dir_ff, p6_dir_ff, p7_dir_ff, p8_dir_ff;
    logic [6:0] mem_ptr_ff;
    logic [7:0] mem_ff [MEM_DEPTH];
    logic [7:0] cnt1_preset_ff, cnt1_count_ff, cnt1_pre_ff;
    logic [7:0] sys_clk_ff, remote_ff, flags_ff, rdata_ff;
    wire ctrl_ok = (sfr_space_i == SPACE_CTRL) && !control_page_select_i;
    wire data_sp = (sfr_space_i == SPACE_DATA);
    wire wr_ctrl = sfr_wr_i && ctrl_ok;
    wire wr_data = sfr_wr_i && data_sp;
    wire wr_p5 = wr_ctrl && sfr_addr_i == `OFS_P5_DIR;
    wire wr_p6 = wr_ctrl && sfr_addr_i == `OFS_P6_DIR;
    wire wr_p7 = wr_ctrl && sfr_addr_i == `OFS_P7_DIR;
    wire wr_p8 = wr_ctrl && sfr_addr_i == `OFS_P8_DIR;
    wire wr_ptr = wr_ctrl && sfr_addr_i == `OFS_MEM_PTR;
    wire wr_win = wr_ctrl && sfr_addr_i == `OFS_MEM_WIN;
    wire wr_pre = wr_ctrl && sfr_addr_i == `OFS_CNT1_PRESET;
    wire wr_sys = wr_data && sfr_addr_i == `OFS_SYS_CLK;
    wire wr_rem = wr_data && sfr_addr_i == `OFS_REMOTE;
    wire wr_isr = wr_data && sfr_addr_i == `OFS_IRQ_FLAGS;
    wire [7:0] win_data = mem_ff[mem_ptr_ff];
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (ctrl_ok) begin
            unique case (sfr_addr_i)
                `OFS_P5_DIR: rd_mux = p5_dir_ff;
                `OFS_P6_DIR: rd_mux = p6_dir_ff;
                `OFS_P7_DIR: rd_mux = p7_dir_ff;
                `OFS_P8_DIR: rd_mux = p8_dir_ff;
                `OFS_MEM_PTR: rd_mux = {1'b0, mem_ptr_ff};
                `OFS_MEM_WIN: rd_mux = win_data;
                `OFS_CNT1_PRESET: rd_mux = cnt1_preset_ff;
                default: rd_mux = 8'h00;
            endcase
        end else if (data_sp) begin
            unique case (sfr_addr_i)
                `OFS_SYS_CLK: rd_mux = sys_clk_ff;
                `OFS_REMOTE: rd_mux = remote_ff;
                `OFS_IRQ_FLAGS: rd_mux = flags_ff;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rdata_ff <= `RST_ZERO;
        end else if (sfr_rd_i) begin
            rdata_ff <= rd_mux;
        end
    end
    assign sfr_rdata_o = rdata_ff;

    // ************************************************************
    // Plain storage registers
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            p5_dir_ff <= `RST_DIR;
            p6_dir_ff <= `RST_DIR;
            p7_dir_ff <= `RST_DIR;
            p8_dir_ff <= `RST_DIR;
            mem_ptr_ff <= 7'h00;
            sys_clk_ff <= `RST_ZERO;
            remote_ff <= `RST_ZERO;
        end else begin
            if (wr_p5) p5_dir_ff <= sfr_wdata_i;
            if (wr_p6) p6_dir_ff <= sfr_wdata_i;
            if (wr_p7) p7_dir_ff <= sfr_wdata_i;
            if (wr_p8) p8_dir_ff <= sfr_wdata_i;
            if (wr_ptr) mem_ptr_ff <= sfr_wdata_i[6:0];
            if (wr_sys) sys_clk_ff <= {1'b0, sfr_wdata_i[6:0]};
            if (wr_rem) remote_ff <= sfr_wdata_i & 8'hef;
        end
    end

    // Data memory has no reset, as in a real RAM
    always_ff @(posedge ref_clk_i) begin
        if (wr_win) begin
            mem_ff[mem_ptr_ff] <= sfr_wdata_i;
        end
    end

    // ************************************************************
    // Clock control and power mode
    // ************************************************************
    wire [2:0] clk_code = sys_clk_ff[`SBP_CLK_HI:`SBP_CLK_LO];
    wire [1:0] bf_code = sys_clk_ff[`SBP_BF_LO+1:`SBP_BF_LO];
    wire cpu_src = sys_clk_ff[`SBP_SRC];
    logic [7:0] mult_num_ff;
    logic [1:0] mult_shift_ff;
    logic [3:0] boost_cnt_ff;
    logic boost_tick_ff;
    power_state_t pwr_ff, nxt_pwr;
    wire boost_wrap = boost_cnt_ff >= boost_top(bf_code);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            mult_num_ff <= `MUL_X130;
            mult_shift_ff <= 2'h0;
        end else begin
            mult_num_ff <= mult_num(clk_code);
            mult_shift_ff <= mult_shift(clk_code);
        end
    end

    // Booster tick is one cycle per divided slow-clock period
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            boost_cnt_ff <= 4'h0;
            boost_tick_ff <= 1'b0;
        end else begin
            boost_tick_ff <= slow_tick_i && boost_wrap;
            if (slow_tick_i) begin
                boost_cnt_ff <= boost_wrap ? 4'h0 : boost_cnt_ff + 4'h1;
            end
        end
    end

    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            PWR_RUN: begin
                if (low_power_instruction_i) begin
                    nxt_pwr = sys_clk_ff[`SBP_IDLE] ? PWR_IDLE : PWR_SLEEP;
                end
            end
            PWR_IDLE, PWR_SLEEP: begin
                if (wake_i) nxt_pwr = PWR_RUN;
            end
            default: nxt_pwr = PWR_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) pwr_ff <= PWR_RUN;
        else pwr_ff <= nxt_pwr;
    end

    assign pll_mult_num_o = mult_num_ff;
    assign pll_mult_shift_o = mult_shift_ff;
    assign cpu_source_select_o = cpu_src;
    assign main_osc_enable_o = cpu_src;
    assign booster_tick_o = boost_tick_ff;
    assign power_state_o = pwr_ff;

    // ************************************************************
    // Remote / PWM waveform
    // ************************************************************
    wire rmt_en = remote_ff[`RMT_EN];
    wire carrier_en = remote_ff[`RMT_CARRIER];
    wire low_only = remote_ff[`RMT_LOW_ONLY];
    wire pin_sel = remote_ff[`RMT_PIN];
    logic wave_hi_ff, carrier_ff;

    // Long low pulse mode never enters the high phase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || !rmt_en) begin
            wave_hi_ff <= 1'b0;
            carrier_ff <= 1'b0;
        end else begin
            if (cnt2_uf_i) carrier_ff <= !carrier_ff;
            if (low_only) wave_hi_ff <= 1'b0;
            else if (wave_hi_ff && hpwt_uf_i) wave_hi_ff <= 1'b0;
            else if (!wave_hi_ff && lpwt_uf_i) wave_hi_ff <= 1'b1;
        end
    end
    wire wave = wave_hi_ff || (carrier_en && carrier_ff);
    wire remote_drive = rmt_en && pin_sel;

    // ************************************************************
    // Pin synchronisers and port change detect
    // ************************************************************
    logic [7:4] p5_s1_ff, p5_s2_ff, p5_s3_ff;
    logic [7:0] p6_s1_ff, p6_s2_ff, p6_s3_ff;
    logic [7:0] p8_s1_ff, p8_s2_ff, p8_s3_ff;
    logic sync_ok_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            p5_s1_ff <= 4'h0;
            p5_s2_ff <= 4'h0;
            p5_s3_ff <= 4'h0;
            p6_s1_ff <= 8'h00;
            p6_s2_ff <= 8'h00;
            p6_s3_ff <= 8'h00;
            p8_s1_ff <= 8'h00;
            p8_s2_ff <= 8'h00;
            p8_s3_ff <= 8'h00;
            sync_ok_ff <= 1'b0;
        end else begin
            p5_s1_ff <= p5_pin_i;
            p5_s2_ff <= p5_s1_ff;
            p5_s3_ff <= p5_s2_ff;
            p6_s1_ff <= p6_pin_i;
            p6_s2_ff <= p6_s1_ff;
            p6_s3_ff <= p6_s2_ff;
            p8_s1_ff <= p8_pin_i;
            p8_s2_ff <= p8_s1_ff;
            p8_s3_ff <= p8_s2_ff;
            sync_ok_ff <= 1'b1;
        end
    end

    // Only pins set as inputs report a change, so own drive is not seen
    wire p6_chg = |((p6_s2_ff ^ p6_s3_ff) & p6_dir_ff);
    wire p8_chg = |((p8_s2_ff ^ p8_s3_ff) & p8_dir_ff &
        {{4{!p5_dir_ff[3]}}, {4{!p5_dir_ff[2]}}});
    wire port_chg = sync_ok_ff && (p6_chg || p8_chg);
    wire ext_a = remote_ff[`RMT_EXTA] && p5_s2_ff[4] && !p5_s3_ff[4];
    wire ext_b = remote_ff[`RMT_EXTB] && p5_s2_ff[5] && !p5_s3_ff[5];
    assign tick_pin_o = remote_ff[`RMT_TICK] && p5_s2_ff[6];

    // ************************************************************
    // Counter 1
    // ************************************************************
    wire [7:0] pre_top = 8'((9'h002 << cnt1_prescale_i) - 9'h001);
    wire pre_done = cnt1_pre_ff >= pre_top;
    wire cnt1_step = counter_one_enable_i && cnt1_tick_i && pre_done;
    wire cnt1_uf = cnt1_step && (cnt1_count_ff == 8'h00);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt1_preset_ff <= `RST_ZERO;
            cnt1_count_ff <= `RST_ZERO;
            cnt1_pre_ff <= 8'h00;
        end else begin
            if (wr_pre) cnt1_preset_ff <= sfr_wdata_i;
            if (counter_one_enable_i && cnt1_tick_i) begin
                cnt1_pre_ff <= pre_done ? 8'h00 : cnt1_pre_ff + 8'h01;
            end
            if (wr_pre) cnt1_count_ff <= sfr_wdata_i;
            else if (cnt1_uf) cnt1_count_ff <= cnt1_preset_ff;
            else if (cnt1_step) cnt1_count_ff <= cnt1_count_ff - 8'h01;
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    wire [7:0] events = {port_chg, lpwt_uf_i, hpwt_uf_i, cnt2_uf_i,
        cnt1_uf, ext_b, ext_a, tick_ovf_i};
    wire [7:0] keep = wr_isr ? (flags_ff & sfr_wdata_i) : flags_ff;

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) flags_ff <= `RST_ZERO;
        else flags_ff <= keep | events;
    end
    assign irq_flags_o = flags_ff;

    // ************************************************************
    // Pin drive
    // ************************************************************
    wire [3:0] seg_sel = p5_dir_ff[3:0];
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            p5_o <= 4'h0;
            p5_oe_o <= 4'h0;
            p6_o <= 8'h00;
            p6_oe_o <= 8'h00;
            p7_o <= 8'h00;
            p7_oe_o <= 8'h00;
            p8_o <= 8'h00;
            p8_oe_o <= 8'h00;
        end else begin
            p5_o <= {remote_drive ? wave : p5_data_i[7], p5_data_i[6:4]};
            p5_oe_o <= ~p5_dir_ff[7:4];
            p6_oe_o <= ~p6_dir_ff;
            p6_o <= p6_data_i;
            p7_o[3:0] <= seg_sel[0] ? lcd_seg_i[19:16] : p7_data_i[3:0];
            p7_o[7:4] <= seg_sel[1] ? lcd_seg_i[23:20] : p7_data_i[7:4];
            p8_o[3:0] <= seg_sel[2] ? lcd_seg_i[27:24] : p8_data_i[3:0];
            p8_o[7:4] <= seg_sel[3] ? lcd_seg_i[31:28] : p8_data_i[7:4];
            p7_oe_o <= ~p7_dir_ff | {{4{seg_sel[1]}}, {4{seg_sel[0]}}};
            p8_oe_o <= ~p8_dir_ff | {{4{seg_sel[3]}}, {4{seg_sel[2]}}};
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_flag_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (|events) |=> ((flags_ff & $past(events)) == $past(events));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");

    property p_flag_sticky;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (flags_ff[`ISR_TICK] && !wr_isr) |=> flags_ff[`ISR_TICK];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clearing write");

    property p_enter_idle;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (pwr_ff == PWR_RUN && low_power_instruction_i &&
         sys_clk_ff[`SBP_IDLE]) |=> (pwr_ff == PWR_IDLE);
    endproperty
    a_enter_idle: assert property (p_enter_idle)
        else $error("idle not entered");

    property p_enter_sleep;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (pwr_ff == PWR_RUN && low_power_instruction_i &&
         !sys_clk_ff[`SBP_IDLE]) |=> (pwr_ff == PWR_SLEEP);
    endproperty
    a_enter_sleep: assert property (p_enter_sleep)
        else $error("sleep not entered");

    property p_page_block;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sfr_wr_i && control_page_select_i) |=> $stable(p6_dir_ff);
    endproperty
    a_page_block: assert property (p_page_block)
        else $error("control write taken on page one");

    property p_cnt1_reload;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cnt1_uf && !wr_pre) |=> (cnt1_count_ff == $past(cnt1_preset_ff))
            && flags_ff[`ISR_CNT1];
    endproperty
    a_cnt1_reload: assert property (p_cnt1_reload)
        else $error("counter one did not reload on underflow");

    property p_cnt1_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (!counter_one_enable_i && !wr_pre) |=> $stable(cnt1_count_ff);
    endproperty
    a_cnt1_hold: assert property (p_cnt1_hold)
        else $error("counter one moved while disabled");

    property p_remote_off;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !rmt_en |-> ##1 (!wave_hi_ff && p5_oe_o[7] == !$past(p5_dir_ff[7]));
    endproperty
    a_remote_off: assert property (p_remote_off)
        else $error("remote pin not under direction control");

    property p_ptr_top;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sfr_rd_i && ctrl_ok && sfr_addr_i == `OFS_MEM_PTR) |=>
            !sfr_rdata_o[7];
    endproperty
    a_ptr_top: assert property (p_ptr_top)
        else $error("pointer top bit read as one");

    property p_main_osc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_sys |=> main_osc_enable_o == $past(sfr_wdata_i[`SBP_SRC]);
    endproperty
    a_main_osc: assert property (p_main_osc)
        else $error("main oscillator enable disagrees with source bit");
endmodule

`default_nettype wire

// file: sim/test_mcu_special_function_regs.sv
// Purpose: Self-checking bench for the special function register bank.
// Assumes: Inputs change at the falling edge; read data one cycle later.
// Notes:   Waits are bounded; a check that runs out counts a mismatch.
`include "sfr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_mcu_special_function_regs;
    import sfr_pkg::*;
    // ********
    // Signals
    // ********
    logic ref_clk_i = '0, rst_b_i = '0, sfr_wr_i = '0, sfr_rd_i = '0;
    sfr_space_t sfr_space_i = SPACE_CTRL;
    logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o;
    logic control_page_select_i = '0, low_power_instruction_i = '0;
    logic wake_i = '0, slow_tick_i = '0, cnt1_tick_i = '0;
    logic counter_one_enable_i = '0, tick_pin_o, booster_tick_o;
    logic cpu_source_select_o, main_osc_enable_o;
    logic [3:0] ev = '0;
    logic [2:0] cnt1_prescale_i = '0;
    logic [1:0] pll_mult_shift_o;
    logic [7:0] pll_mult_num_o, irq_flags_o, p6_pin_i = '0, p8_pin_i = '0;
    logic [7:4] p5_data_i = 4'ha, p5_pin_i = '0, p5_o, p5_oe_o;
    logic [7:0] p6_data_i = 8'h5a, p7_data_i = 8'h3c, p8_data_i = 8'hc3;
    logic [7:0] p6_o, p6_oe_o, p7_o, p7_oe_o, p8_o, p8_oe_o;
    logic [31:16] lcd_seg_i = 16'ha5a5;
    power_state_t power_state_o;
    int n_mismatch = 0;
    int checks = 0;

    mcu_special_function_regs DUT (
        .ref_clk_i, .rst_b_i, .sfr_space_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .control_page_select_i,
        .low_power_instruction_i, .wake_i, .power_state_o, .slow_tick_i,
        .pll_mult_num_o, .pll_mult_shift_o, .cpu_source_select_o,
        .main_osc_enable_o, .booster_tick_o, .hpwt_uf_i(ev[0]),
        .lpwt_uf_i(ev[1]), .cnt2_uf_i(ev[2]), .tick_ovf_i(ev[3]),
        .cnt1_tick_i, .counter_one_enable_i, .cnt1_prescale_i, .irq_flags_o,
        .tick_pin_o, .p5_data_i, .p5_pin_i, .p5_o, .p5_oe_o, .p6_data_i,
        .p6_pin_i, .p6_o, .p6_oe_o, .p7_data_i, .p7_o, .p7_oe_o, .p8_data_i,
        .p8_pin_i, .p8_o, .p8_oe_o, .lcd_seg_i);

    always #2.5 ref_clk_i = ~ref_clk_i;

    // ********
    // Tasks
    // ********
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Strobe drops, then one idle cycle so the next call never re-raises it
    task automatic wr(input sfr_space_t s, input logic [7:0] a, d);
        sfr_space_i = s;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'h1;
        cyc(1);
        sfr_wr_i = 1'h0;
        cyc(1);
    endtask

    task automatic rd(input sfr_space_t s, input logic [7:0] a, exp);
        sfr_space_i = s;
        sfr_addr_i = a;
        sfr_rd_i = 1'h1;
        cyc(1);
        sfr_rd_i = 1'h0;
        chk(sfr_rdata_o, exp);
        cyc(1);
    endtask

    task automatic close_out;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        for (int i = 6; i <= 8; i++) begin
            rd(SPACE_CTRL, 8'(i), 8'hff);
        end
        wr(SPACE_CTRL, `OFS_MEM_PTR, 8'h85);
        rd(SPACE_CTRL, `OFS_MEM_PTR, 8'h05);
        wr(SPACE_CTRL, `OFS_MEM_WIN, 8'hc3);
        rd(SPACE_CTRL, `OFS_MEM_WIN, 8'hc3);
        wr(SPACE_CTRL, `OFS_CNT1_PRESET, 8'h5a);
        rd(SPACE_CTRL, `OFS_CNT1_PRESET, 8'h5a);
        control_page_select_i = 1'h1;
        wr(SPACE_CTRL, `OFS_P6_DIR, 8'h00);
        rd(SPACE_CTRL, `OFS_P6_DIR, 8'h00);
        control_page_select_i = 1'h0;
        rd(SPACE_CTRL, `OFS_P6_DIR, 8'hff);
        rd(SPACE_CTRL, 8'h20, 8'h00);
    endtask

    task automatic t_clk;
        logic [2:0] c;
        logic [7:0] exp_num;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(SPACE_DATA, `OFS_SYS_CLK, {1'h0, c, 3'h0, c[0]});
            exp_num = c[2] ? 8'hf4 : (c == 3'h0 ? 8'h82 : 8'h41);
            chk(pll_mult_num_o, exp_num);
            exp_num = (c[2] || c == 3'h0) ? 8'h00 : 8'(c - 3'h1);
            chk({6'h00, pll_mult_shift_o}, exp_num);
            chk({7'h00, cpu_source_select_o}, {7'h00, c[0]});
            chk({7'h00, main_osc_enable_o}, {7'h00, c[0]});
        end
    endtask

    task automatic t_power;
        for (int i = 0; i < 2; i++) begin
            wr(SPACE_DATA, `OFS_SYS_CLK, i ? 8'h08 : 8'h00);
            low_power_instruction_i = 1'h1;
            cyc(1);
            low_power_instruction_i = 1'h0;
            cyc(1);
            chk({6'h00, power_state_o}, i ? 8'h01 : 8'h02);
            wake_i = 1'h1;
            cyc(1);
            wake_i = 1'h0;
            cyc(1);
            chk({6'h00, power_state_o}, 8'h00);
        end
    endtask

    // Preset zero makes the first counter step an underflow
    task automatic t_flags;
        ev = 4'hf;
        cyc(1);
        ev = 4'h0;
        p6_pin_i = 8'h01;
        wr(SPACE_CTRL, `OFS_CNT1_PRESET, 8'h00);
        counter_one_enable_i = 1'h1;
        cnt1_tick_i = 1'h1;
        for (int i = 0; i < 20 && irq_flags_o !== 8'hf9; i++) begin
            cyc(1);
        end
        cnt1_tick_i = 1'h0;
        counter_one_enable_i = 1'h0;
        chk(irq_flags_o, 8'hf9);
        wr(SPACE_DATA, `OFS_IRQ_FLAGS, 8'hf7);
        chk(irq_flags_o, 8'hf1);
        wr(SPACE_DATA, `OFS_IRQ_FLAGS, 8'h00);
        chk(irq_flags_o, 8'h00);
    endtask

    task automatic pulse(input logic [3:0] e);
        ev = e;
        cyc(1);
        ev = 4'h0;
        cyc(1);
    endtask

    // Pin 7 driven, pins 6..4 inputs, as software must set them
    task automatic t_wave;
        wr(SPACE_CTRL, `OFS_P5_DIR, 8'h70);
        wr(SPACE_DATA, `OFS_REMOTE, 8'h88);
        chk({7'h00, p5_o[7]}, 8'h00);
        pulse(4'h2);
        chk({7'h00, p5_o[7]}, 8'h01);
        pulse(4'h1);
        chk({7'h00, p5_o[7]}, 8'h00);
        wr(SPACE_DATA, `OFS_REMOTE, 8'hc8);
        pulse(4'h4);
        chk({7'h00, p5_o[7]}, 8'h01);
        wr(SPACE_DATA, `OFS_REMOTE, 8'ha8);
        pulse(4'h2);
        chk({7'h00, p5_o[7]}, 8'h00);
        wr(SPACE_DATA, `OFS_REMOTE, 8'h08);
        chk({6'h00, p5_oe_o[7], p5_o[7]}, 8'h03);
    endtask

    task automatic t_pins;
        wr(SPACE_DATA, `OFS_REMOTE, 8'h07);
        wr(SPACE_DATA, `OFS_IRQ_FLAGS, 8'h00);
        p5_pin_i = 4'h7;
        cyc(4);
        chk(irq_flags_o, 8'h06);
        chk({7'h00, tick_pin_o}, 8'h01);
        p8_pin_i = 8'h10;
        cyc(4);
        chk(irq_flags_o, 8'h86);
    endtask

    // Slow tick every cycle: 32 ticks give 32, 8, 4, 2 booster pulses
    task automatic t_boost;
        int n;
        for (int b = 0; b < 4; b++) begin
            wr(SPACE_DATA, `OFS_SYS_CLK, 8'(b << 1));
            n = 0;
            slow_tick_i = 1'h1;
            for (int k = 0; k < 32; k++) begin
                cyc(1);
                if (booster_tick_o === 1'h1) n++;
            end
            slow_tick_i = 1'h0;
            cyc(1);
            chk(8'(n), b == 0 ? 8'h20 : 8'(32 >> (b + 1)));
        end
    endtask

    task automatic t_dir;
        wr(SPACE_CTRL, `OFS_P6_DIR, 8'h0f);
        chk(p6_oe_o, 8'hf0);
        chk(p6_o, 8'h5a);
        wr(SPACE_CTRL, `OFS_P5_DIR, 8'h55);
        chk({4'h0, p5_oe_o}, 8'h0a);
        chk(p7_o, 8'h35);
        chk(p8_o, 8'hc5);
        chk(p7_oe_o, 8'h0f);
        chk(p8_oe_o, 8'h0f);
    endtask

    initial begin
        cyc(2);
        rst_b_i = 1'h1;
        t_regs();
        t_clk();
        t_power();
        t_flags();
        t_wave();
        t_pins();
        t_boost();
        t_dir();
        close_out();
    end
endmodule
`default_nettype wire
